// File: rtl/qlf_top.v
// Quad-lane input elastic FIFO: lane capture, 8-entry FIFO, pointer sync,
// bypass, ramp insert and constant-output override, with an Avalon-MM slave.
// Assumes the lane clock and converter clock arrive as plain inputs that are
// much slower than i_clk_sys, so each of their edges is seen as a level change.
//
// Function
// RULE1 - Two 16-bit lanes: AB and CD
// RULE2 - A,C on rising edge; B,D on falling
// RULE3 - Source interleaves A0,B0,A1,B1; bit0 is LSB
// RULE4 - Lane sync period is multiple of 8
// RULE5 - Lane sync sampled on rising edges only
// RULE6 - Lane sync pulse at least half period
// RULE7 - Elastic FIFO, four channels, 8 entries
// RULE8 - One 64-bit sample written per lane period
// RULE9 - Read one sample per converter/interp tick
// RULE10 - Each write or read advances its pointer
// RULE11 - Reset: write to 0, read to offset
// RULE12 - System keeps write and read rates equal
// RULE13 - Write selector picks source; rising edge resets
// RULE14 - Read selector; lane sync recaptured on read side
// RULE15 - Output strobe sampled by converter clock
// RULE16 - Both selectors 1000: software sync resets both
// RULE17 - Both selectors 0000: no pointer resets
// RULE18 - Pointers wrap on their own
// RULE19 - Periodic syncs repeat at n times 8
// RULE20 - Override drives all channels, latched by lane clock
// RULE21 - FIFO disabled: bypass, pointers unused
// RULE22 - Ramp pattern replaces input at FIFO input
// RULE23 - 3-bit pointers; edge-detected registered sync
// RULE24 - Two flops recapture lane sync before read
//
// Implementation choice: register access over Avalon-MM.
`include "qlf_consts.vh"

module qlf_top (
  // System
  input  wire        i_clk_sys,
  input  wire        i_rst,
  // Avalon-MM slave
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Lane side
  input  wire        i_lane_sample_clock,
  input  wire [15:0] i_lane_pair_ab,
  input  wire [15:0] i_lane_pair_cd,
  input  wire        i_input_strobe,
  input  wire        i_sync_pin,
  // Converter side
  input  wire        i_converter_clock,
  input  wire        i_output_strobe,
  // Converter channel outputs
  output reg  [15:0] o_ch_a,
  output reg  [15:0] o_ch_b,
  output reg  [15:0] o_ch_c,
  output reg  [15:0] o_ch_d,
  output reg         o_sample_valid
);

  // ===================================================================
  // Declarations
  reg  [4:0]  ctrl_r;
  reg  [3:0]  wsel_r;
  reg  [3:0]  rsel_r;
  reg  [4:0]  interp_r;
  reg  [2:0]  offset_r;
  reg  [15:0] override_value_r;
  reg         sif_pulse_r;
  reg         ack_r;
  reg         collide_r;

  reg         lclk_d_r;
  reg         cclk_d_r;
  reg  [15:0] a_r;
  reg  [15:0] c_r;
  reg  [63:0] asm_r;
  reg  [15:0] ramp_r;
  reg  [15:0] ovr_latched_r;
  reg  [63:0] mem [0:7];
  reg  [2:0]  wptr_r;
  reg  [2:0]  rptr_r;
  reg         lsync_pin_r;
  reg         lsync_input_strobe_r;
  reg         wsrc_d_r;
  reg         rsync1_r;
  reg         rsync2_r;
  reg         rsync3_r;
  reg         output_strobe_s_r;
  reg         output_strobe_d_r;
  reg  [4:0]  div_cnt_r;
  reg  [4:0]  div_cnt_nxt;
  reg  [63:0] rd_sample;

  wire        lane_rise;
  wire        lane_fall;
  wire        conv_rise;
  wire        fifo_ena;
  wire        sif_mode;
  wire        wsrc;
  wire        rsrc_lane;
  wire        wr_reset;
  wire        rd_reset;
  wire        output_strobe_rise;
  wire        rd_tick;
  wire [4:0]  interp_eff;
  wire [63:0] wr_sample;
  wire        bus_req;
  wire        bus_go;

  // ===================================================================
  // Register bus
  // Answer one cycle after the request; a write lands at the edge where
  // waitrequest is seen low, so the master never has to retry.
  assign bus_req           = i_avs_read | i_avs_write;
  assign bus_go            = bus_req & ack_r;
  assign o_avs_waitrequest = bus_req & ~ack_r;

  // Acknowledge toggle and read data capture
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack_r          <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (i_avs_read & ~ack_r) begin
        case (i_avs_address)
          `QLF_ADDR_CTRL:     o_avs_readdata <= {27'h000_0000, ctrl_r};
          `QLF_ADDR_SYNCSEL:  o_avs_readdata <= {24'h00_0000, rsel_r, wsel_r};
          `QLF_ADDR_INTERP:   o_avs_readdata <= {27'h000_0000, interp_r};
          `QLF_ADDR_OFFSET:   o_avs_readdata <= {29'h0000_0000, offset_r};
          `QLF_ADDR_STATUS:   o_avs_readdata <= {23'h00_0000, collide_r, 1'b0, rptr_r, 1'b0, wptr_r};
          `QLF_ADDR_OVERRIDE: o_avs_readdata <= {16'h0000, override_value_r};
          default:            o_avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes; the software sync bit is a self-clearing pulse
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r           <= `QLF_CTRL_RST;
      wsel_r           <= `QLF_SEL_RST;
      rsel_r           <= `QLF_SEL_RST;
      interp_r         <= `QLF_INTERP_RST;
      offset_r         <= `QLF_OFFSET_RST;
      override_value_r <= `QLF_OVR_RST;
      sif_pulse_r      <= 1'b0;
    end else begin
      sif_pulse_r <= 1'b0;
      if (i_avs_write & bus_go) begin
        case (i_avs_address)
          `QLF_ADDR_CTRL: begin
            ctrl_r      <= {1'b0, i_avs_writedata[3:0]};
            sif_pulse_r <= i_avs_writedata[`QLF_CTRL_SIF_SYNC];
          end
          `QLF_ADDR_SYNCSEL: begin
            wsel_r <= i_avs_writedata[3:0];
            rsel_r <= i_avs_writedata[7:4];
          end
          `QLF_ADDR_INTERP:   interp_r <= i_avs_writedata[4:0];
          `QLF_ADDR_OFFSET:   offset_r <= i_avs_writedata[2:0];
          `QLF_ADDR_OVERRIDE: override_value_r <= i_avs_writedata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ===================================================================
  // Clock edge detection
  // Both foreign clocks are oversampled, so their edges become enables.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lclk_d_r <= 1'b0;
      cclk_d_r <= 1'b0;
    end else begin
      lclk_d_r <= i_lane_sample_clock;
      cclk_d_r <= i_converter_clock;
    end
  end

  assign lane_rise = i_lane_sample_clock & ~lclk_d_r;
  assign lane_fall = ~i_lane_sample_clock & lclk_d_r;
  assign conv_rise = i_converter_clock & ~cclk_d_r;
  assign fifo_ena  = ctrl_r[`QLF_CTRL_FIFO_ENA];

  // ===================================================================
  // Lane capture and sample assembly
  // First half on the rising edge, second half on the falling edge.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      a_r           <= 16'h0000;
      c_r           <= 16'h0000;
      asm_r         <= 64'h0000_0000_0000_0000;
      ramp_r        <= 16'h0000;
      ovr_latched_r <= `QLF_OVR_RST;
    end else begin
      if (lane_rise) begin
        a_r           <= i_lane_pair_ab; // RULE2
        c_r           <= i_lane_pair_cd; // RULE1
        ovr_latched_r <= override_value_r; // RULE20
      end
      if (lane_fall) begin
        asm_r  <= {i_lane_pair_cd, c_r, i_lane_pair_ab, a_r}; // RULE2
        ramp_r <= ramp_r + 16'h0001;
      end
    end
  end

  // Ramp insert replaces the assembled word at the FIFO input
  assign wr_sample = ctrl_r[`QLF_CTRL_RAMP_ENA] ?
                     {ramp_r, ramp_r, ramp_r, ramp_r} : // RULE22
                     {i_lane_pair_cd, c_r, i_lane_pair_ab, a_r};

  // ===================================================================
  // Sync source selection on the lane side
  // Sync levels are taken only on lane rising edges, never on falling.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lsync_pin_r  <= 1'b0;
      lsync_input_strobe_r <= 1'b0;
      wsrc_d_r     <= 1'b0;
    end else if (lane_rise) begin
      lsync_pin_r  <= i_sync_pin; // RULE5
      lsync_input_strobe_r <= i_input_strobe; // RULE5
      wsrc_d_r     <= wsrc; // RULE23
    end
  end

  assign sif_mode  = (wsel_r == `QLF_SEL_SIF_ONLY) & (rsel_r == `QLF_SEL_SIF_ONLY); // RULE16
  assign wsrc      = (wsel_r[`QLF_SEL_SYNC_PIN] & lsync_pin_r) |
                     (wsel_r[`QLF_SEL_ISTROBE] & lsync_input_strobe_r); // RULE13
  assign rsrc_lane = (rsel_r[`QLF_SEL_SYNC_PIN] & lsync_pin_r) |
                     (rsel_r[`QLF_SEL_ISTROBE] & lsync_input_strobe_r); // RULE14

  // Zero selectors gate every source off, so no reset can occur
  assign wr_reset  = (lane_rise & wsrc & ~wsrc_d_r) | (sif_mode & sif_pulse_r); // RULE17

  // ===================================================================
  // Write pointer and storage
  // A pin or strobe reset never shares a cycle with a write (opposite edges); a software sync can, and then the reset wins.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wptr_r <= `QLF_WPTR_RST;
    end else if (wr_reset) begin
      wptr_r <= `QLF_WPTR_RST; // RULE11
    end else if (lane_fall) begin
      wptr_r <= wptr_r + 3'h1; // RULE10 RULE18
    end
  end

  // Storage has no reset; entries are data only
  always @(posedge i_clk_sys) begin
    if (lane_fall) begin
      mem[wptr_r] <= wr_sample; // RULE8 RULE7
    end
  end

  // ===================================================================
  // Read clock divider
  // One read tick per interpolation count of converter edges; a value of
  // zero behaves as one to avoid a dead output.
  assign interp_eff = (interp_r == 5'h00) ? 5'h01 : interp_r;
  assign rd_tick    = conv_rise & (div_cnt_r == interp_eff - 5'h01); // RULE9

  always @* begin
    div_cnt_nxt = div_cnt_r;
    if (output_strobe_rise) begin
      div_cnt_nxt = 5'h00;
    end else if (rd_tick) begin
      div_cnt_nxt = 5'h00;
    end else if (conv_rise) begin
      div_cnt_nxt = div_cnt_r + 5'h01;
    end
  end

  // ===================================================================
  // Read-side sync recapture
  // The lane sync crosses into the read-tick domain through two flops;
  // this adds phase ambiguity, which is why the output strobe exists.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= 5'h00;
      rsync1_r  <= 1'b0;
      rsync2_r  <= 1'b0;
      rsync3_r  <= 1'b0;
      output_strobe_s_r  <= 1'b0;
      output_strobe_d_r  <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      if (rd_tick) begin
        rsync1_r <= rsrc_lane; // RULE24
        rsync2_r <= rsync1_r; // RULE24
        rsync3_r <= rsync2_r;
      end
      if (conv_rise) begin
        output_strobe_s_r <= i_output_strobe; // RULE15
        output_strobe_d_r <= output_strobe_s_r;
      end
    end
  end

  assign output_strobe_rise = conv_rise & rsel_r[`QLF_SEL_OSTROBE] & output_strobe_s_r & ~output_strobe_d_r; // RULE15
  assign rd_reset  = output_strobe_rise | (rd_tick & rsync2_r & ~rsync3_r) | (sif_mode & sif_pulse_r); // RULE14 RULE16

  // ===================================================================
  // Read pointer
  // Output strobe also realigns the divider, so it sets the output phase.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rptr_r <= `QLF_OFFSET_RST;
    end else if (rd_reset) begin
      rptr_r <= offset_r; // RULE11
    end else if (rd_tick) begin
      rptr_r <= rptr_r + 3'h1; // RULE10 RULE18
    end
  end

  // Bypass hands the latest assembled sample straight across
  always @* begin
    rd_sample = asm_r; // RULE21
    if (fifo_ena) begin
      rd_sample = mem[rptr_r]; // RULE9
    end
  end

  // ===================================================================
  // Output stage
  // Channels are driven two's complement; offset-binary input flips the MSB.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ch_a         <= 16'h0000;
      o_ch_b         <= 16'h0000;
      o_ch_c         <= 16'h0000;
      o_ch_d         <= 16'h0000;
      o_sample_valid <= 1'b0;
      collide_r      <= 1'b0;
    end else begin
      o_sample_valid <= rd_tick;
      if (rd_tick) begin
        collide_r <= fifo_ena & (rptr_r == wptr_r);
        if (ctrl_r[`QLF_CTRL_OVR_ENA]) begin
          o_ch_a <= {ovr_latched_r[15] ^ ~ctrl_r[`QLF_CTRL_TWOS], ovr_latched_r[14:0]}; // RULE20
          o_ch_b <= {ovr_latched_r[15] ^ ~ctrl_r[`QLF_CTRL_TWOS], ovr_latched_r[14:0]};
          o_ch_c <= {ovr_latched_r[15] ^ ~ctrl_r[`QLF_CTRL_TWOS], ovr_latched_r[14:0]};
          o_ch_d <= {ovr_latched_r[15] ^ ~ctrl_r[`QLF_CTRL_TWOS], ovr_latched_r[14:0]};
        end else begin
          o_ch_a <= {rd_sample[15] ^ ~ctrl_r[`QLF_CTRL_TWOS], rd_sample[14:0]};
          o_ch_b <= {rd_sample[31] ^ ~ctrl_r[`QLF_CTRL_TWOS], rd_sample[30:16]};
          o_ch_c <= {rd_sample[47] ^ ~ctrl_r[`QLF_CTRL_TWOS], rd_sample[46:32]};
          o_ch_d <= {rd_sample[63] ^ ~ctrl_r[`QLF_CTRL_TWOS], rd_sample[62:48]};
        end
      end
    end
  end

endmodule

// File: shared/qlf_consts.vh
// Constants for the quad-lane input elastic FIFO block.
// Assumes a single 25 MHz system clock and a 32-bit Avalon-MM register slave.
`ifndef QLF_CONSTS_VH
`define QLF_CONSTS_VH

// =====================================================================
// Register byte addresses
`define QLF_ADDR_CTRL      8'h00
`define QLF_ADDR_SYNCSEL   8'h04
`define QLF_ADDR_INTERP    8'h08
`define QLF_ADDR_OFFSET    8'h0C
`define QLF_ADDR_STATUS    8'h10
`define QLF_ADDR_OVERRIDE  8'h30

// =====================================================================
// Control register field positions
`define QLF_CTRL_FIFO_ENA  0
`define QLF_CTRL_OVR_ENA   1
`define QLF_CTRL_RAMP_ENA  2
`define QLF_CTRL_TWOS      3
`define QLF_CTRL_SIF_SYNC  4

// Sync selector bit positions
`define QLF_SEL_SYNC_PIN   0
`define QLF_SEL_ISTROBE    1
`define QLF_SEL_OSTROBE    2
`define QLF_SEL_SIF        3

// =====================================================================
// Reset values and the software-sync-only selector code
`define QLF_CTRL_RST       5'h09
`define QLF_SEL_RST        4'h0
`define QLF_SEL_SIF_ONLY   4'h8
`define QLF_INTERP_RST     5'h01
`define QLF_OFFSET_RST     3'h4
`define QLF_WPTR_RST       3'h0
`define QLF_OVR_RST        16'h0000

`endif

// File: tb/qlf_lane_src.sv
// Lane-side source model: DDR lane clock, interleaved lane words, sync.
// Assumes i_clk is the system clock; each lane clock phase lasts 4 clocks.
module qlf_lane_src (
  // Control
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic        i_sync,
  // Lane pins
  output logic             o_lclk,
  output logic      [15:0] o_ab,
  output logic      [15:0] o_cd,
  output logic             o_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  ph_r;
  logic [11:0] k_r;
  initial begin
    {o_lclk, o_ab, o_cd, o_sync, ph_r, k_r} = '0;
  end
  // ======
  // Clock stands still and data churns between frames, so stale data never looks valid
  always @(posedge i_clk) begin
    if (!i_run) begin
      o_lclk <= 1'b0;
      o_ab   <= ~o_ab;
      o_cd   <= ~o_cd;
      o_sync <= 1'b0;
      ph_r   <= 2'd0;
    end else begin
      ph_r <= ph_r + 2'd1;
      if (ph_r == 2'd3) begin
        o_lclk <= ~o_lclk;
        if (!o_lclk) begin
          o_ab   <= {4'hA, k_r};
          o_cd   <= {4'hC, k_r};
          o_sync <= i_sync;
        end else begin
          o_ab <= {4'hB, k_r};
          o_cd <= {4'hD, k_r};
          k_r  <= k_r + 12'h001;
        end
      end
    end
  end
endmodule

// File: tb/qlf_top_assertions.sv
// Checker for qlf_top: register handshake and converter output timing.
// Assumes the converter clock stays low while reset is held.
module qlf_top_assertions (
  // System
  input wire        i_clk_sys,
  input wire        i_rst,
  // Register bus
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  // Converter side
  input wire        i_converter_clock,
  input wire [15:0] o_ch_a,
  input wire [15:0] o_ch_b,
  input wire [15:0] o_ch_c,
  input wire [15:0] o_ch_d,
  input wire        o_sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire req = i_avs_read | i_avs_write;
  // ======
  // Bus steps: one wait cycle, then completion
  sequence req_wait_s; req && o_avs_waitrequest; endsequence
  sequence req_done_s; req && !o_avs_waitrequest; endsequence
  bus_cycle_a: assert property ($rose(req) |-> req_wait_s ##1 req_done_s)
    else $error("request did not finish after one wait cycle");
  wait_once_a: assert property (req_wait_s |=> !o_avs_waitrequest)
    else $error("wait held longer than one cycle");
  idle_nowait_a: assert property (o_avs_waitrequest |-> req)
    else $error("wait raised with no request");
  rd_change_a: assert property ($changed(o_avs_readdata) |-> i_avs_read && !o_avs_waitrequest)
    else $error("read data moved outside a read completion");
  // ======
  // Converter outputs follow read ticks only
  valid_pulse_a: assert property (o_sample_valid |=> !o_sample_valid)
    else $error("valid longer than one cycle");
  tick_valid_a: assert property (o_sample_valid |-> $past(i_converter_clock) && !$past(i_converter_clock, 2))
    else $error("valid without a converter clock rise");
  no_tick_a: assert property (!i_converter_clock |=> !o_sample_valid)
    else $error("valid after a low converter clock");
  out_hold_a: assert property (!o_sample_valid |-> $stable({o_ch_a, o_ch_b, o_ch_c, o_ch_d}))
    else $error("channel output moved without valid");
endmodule

bind qlf_top qlf_top_assertions u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_converter_clock(i_converter_clock), .o_ch_a(o_ch_a), .o_ch_b(o_ch_b), .o_ch_c(o_ch_c),
  .o_ch_d(o_ch_d), .o_sample_valid(o_sample_valid));

// File: tb/quad_lane_input_elastic_fifo_tb.sv
// Bench for the quad-lane elastic FIFO: registers, lane order, pointer syncs,
// bypass, ramp and override. Needs qlf_lane_src and the shared constants.
`include "qlf_consts.vh"
module quad_lane_input_elastic_fifo_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] e;} qlf_row_t;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, run = 1'b0, sync = 1'b0, wait_r, valid, lclk, sync_w;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdw, rdata;
  logic [1:0]  conv_d = 2'b00;
  logic [2:0]  ocnt = 3'h0;
  logic        output_strobe = 1'b0, output_strobe_on = 1'b0, output_strobe_one = 1'b0;
  logic [15:0] ab, cd, cha, chb, chc, chd, exp_ov, prev;
  int          err_total = 0, checks = 0, mode = 0, skip = 0, cyc = 0;
  wire  [11:0] n = prev[11:0] + 12'h001;
  qlf_row_t    rows [8] = '{'{`QLF_ADDR_CTRL, 32'h0000_0009}, '{`QLF_ADDR_SYNCSEL, 32'h0000_0000},
    '{`QLF_ADDR_INTERP, 32'h0000_0001}, '{`QLF_ADDR_OFFSET, 32'h0000_0004}, '{`QLF_ADDR_STATUS, 32'h0000_0040},
    '{`QLF_ADDR_OVERRIDE, 32'h0000_0000}, '{8'h20, 32'h0000_0000}, '{8'h7C, 32'h0000_0000}};
  always #20 clk = ~clk;
  // Converter clock trails the lane clock, so both rates stay equal
  always @(posedge clk) conv_d <= {conv_d[0], lclk};
  // Output strobe changes with the converter rise; periodic form is one period in eight
  always @(posedge clk) begin
    if (conv_d == 2'b01) begin
      ocnt <= ocnt + 3'h1;
      output_strobe <= output_strobe_one | (output_strobe_on & (ocnt == 3'h0));
    end
  end
  qlf_lane_src src (.i_clk(clk), .i_run(run), .i_sync(sync), .o_lclk(lclk), .o_ab(ab), .o_cd(cd), .o_sync(sync_w));
  qlf_top dut (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdw), .o_avs_waitrequest(wait_r), .i_lane_sample_clock(lclk),
    .i_lane_pair_ab(ab), .i_lane_pair_cd(cd), .i_input_strobe(sync_w), .i_sync_pin(sync_w),
    .i_converter_clock(conv_d[1]), .i_output_strobe(output_strobe), .o_ch_a(cha), .o_ch_b(chb), .o_ch_c(chc),
    .o_ch_d(chd), .o_sample_valid(valid));
  // ======
  // Compare and bus tasks
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ch(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wait_r !== 1'b0);
    rdata = rdw;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic setmode(input int m, input int s);
    @(negedge clk);
    mode = m;
    skip = s;
  endtask
  task automatic finish_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ======
  // Output watcher: skips samples still in flight after a mode change
  always @(posedge clk) begin
    if (valid === 1'b1 && mode != 0) begin
      if (skip > 0) skip--;
      else if (mode == 1) chk_ch({chd, chc, chb, cha}, {4'hD, n, 4'hC, n, 4'hB, n, 4'hA, n});
      else if (mode == 2) chk_ch({chd, chc, chb, cha}, {4{prev + 16'h0001}});
      else chk_ch({chd, chc, chb, cha}, {4{exp_ov}});
      prev = cha;
    end
  end
  // Hang guard, well above the expected run of about 1700 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      finish_test();
    end
  end
  // ======
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0000_0000);
      chk_reg(rdata, rows[i].e);
    end
    bus(1'b1, `QLF_ADDR_OVERRIDE, 32'hFFFF_FFFF);
    bus(1'b0, `QLF_ADDR_OVERRIDE, 32'h0000_0000);
    chk_reg(rdata, 32'h0000_FFFF);
    run <= 1'b1;
    setmode(1, 12);
    repeat (400) @(posedge clk);
    setmode(1, 10);
    bus(1'b1, `QLF_ADDR_CTRL, 32'h0000_0008);
    repeat (200) @(posedge clk);
    setmode(2, 10);
    bus(1'b1, `QLF_ADDR_CTRL, 32'h0000_000D);
    repeat (200) @(posedge clk);
    exp_ov = 16'h1234;
    setmode(3, 10);
    bus(1'b1, `QLF_ADDR_OVERRIDE, 32'h0000_1234);
    bus(1'b1, `QLF_ADDR_CTRL, 32'h0000_000B);
    repeat (200) @(posedge clk);
    setmode(3, 10);
    exp_ov = 16'h9234;
    bus(1'b1, `QLF_ADDR_CTRL, 32'h0000_0003);
    repeat (200) @(posedge clk);
    // Periodic output strobe every 8 reads must leave the stream unbroken
    setmode(1, 16);
    bus(1'b1, `QLF_ADDR_CTRL, 32'h0000_0009);
    bus(1'b1, `QLF_ADDR_SYNCSEL, 32'h0000_0040);
    output_strobe_on <= 1'b1;
    repeat (300) @(posedge clk);
    output_strobe_on <= 1'b0;
    repeat (40) @(posedge clk);
    // Pointer syncs with both clocks stopped, so pointers stay put
    setmode(0, 0);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    bus(1'b1, `QLF_ADDR_SYNCSEL, 32'h0000_0088);
    bus(1'b1, `QLF_ADDR_OFFSET, 32'h0000_0006);
    bus(1'b1, `QLF_ADDR_CTRL, 32'h0000_0019);
    bus(1'b0, `QLF_ADDR_STATUS, 32'h0000_0000);
    chk_reg(rdata & 32'h0000_0077, 32'h0000_0060);
    bus(1'b1, `QLF_ADDR_SYNCSEL, 32'h0000_0000);
    bus(1'b1, `QLF_ADDR_OFFSET, 32'h0000_0002);
    bus(1'b1, `QLF_ADDR_CTRL, 32'h0000_0019);
    bus(1'b0, `QLF_ADDR_STATUS, 32'h0000_0000);
    chk_reg(rdata & 32'h0000_0077, 32'h0000_0060);
    // Sync pin resets the write side on the lane rise after capture and the read side after recapture
    bus(1'b1, `QLF_ADDR_SYNCSEL, 32'h0000_0011);
    sync <= 1'b1;
    run <= 1'b1;
    @(posedge lclk);
    @(posedge clk);
    sync <= 1'b0;
    repeat (3) @(negedge lclk);
    @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, `QLF_ADDR_STATUS, 32'h0000_0000);
    chk_reg(rdata & 32'h0000_0077, 32'h0000_0022);
    // Single output strobe: seen on one converter rise, acts on the next
    bus(1'b1, `QLF_ADDR_SYNCSEL, 32'h0000_0040);
    bus(1'b1, `QLF_ADDR_OFFSET, 32'h0000_0005);
    output_strobe_one <= 1'b1;
    run <= 1'b1;
    repeat (2) @(posedge conv_d[1]);
    @(posedge clk);
    run <= 1'b0;
    output_strobe_one <= 1'b0;
    repeat (8) @(posedge clk);
    bus(1'b0, `QLF_ADDR_STATUS, 32'h0000_0000);
    chk_reg(rdata & 32'h0000_0070, 32'h0000_0050);
    // Reset with the lanes stopped restores control defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `QLF_ADDR_CTRL, 32'h0000_0000);
    chk_reg(rdata, 32'h0000_0009);
    finish_test();
  end
endmodule
